// [indirect_ops.v]
// Purpose: Executes indirect store, no-op, option load, software reset and
//          return from interrupt for an 8-bit core, driven over Wishbone
// Assumes: Classic Wishbone slave, 10 MHz clock, synchronous active-low reset
// Notes: One instruction cycle spans TCY_CLKS clocks, marked by an enable
//
// Added by the designer: the Wishbone register port and the register addresses.
`include "indirect_ops_regs.vh"

// Functional notes
// - Store work register at pointer-derived address
// - Relative mode: pointer plus signed offset
// - Pre modes step pointer, then store
// - Post modes store, then step pointer
// - Pointers are 16 bits, wrap around
// - Pointer stepping leaves status flags alone
// - Option load copies work register, flags untouched
// - Software reset resets all but power control, clears its flag
// - Return pops stack into program counter
// - Return sets global interrupt enable bit
// - Return takes two cycles, discards prefetch
module indirect_ops #(
  parameter PC_W = 15,
  parameter MEM_AW = 8,
  parameter TCY = `TCY_CLKS
) (
  input wire clk_i,
  input wire nrst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg device_reset_o,
  output wire [7:0] option_o,
  output wire global_irq_enable_o
);
  localparam S_IDLE = 4'b0001;
  localparam S_PEND = 4'b0010;
  localparam S_FLUSH = 4'b0100;
  localparam S_RST = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [12:0] instr;
  reg [7:0] work;
  reg [15:0] file_pointer_0;
  reg [15:0] file_pointer_1;
  reg [7:0] option_reg;
  reg [7:0] power_control_register;
  reg [7:0] irq_control_register;
  reg [2:0] status_flags;
  reg [PC_W-1:0] pc;
  reg [PC_W-1:0] stack_top_entry;
  reg [3:0] stack_ptr;
  reg [MEM_AW-1:0] mem_addr;
  reg [7:0] div_cnt;
  wire cyc_en;
  wire int_rst;
  wire bus_req;
  wire bus_wr;
  wire [7:0] mem_rdata;

  assign int_rst = !nrst_i || (state == S_RST);
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;
  assign option_o = option_reg;
  assign global_irq_enable_o = irq_control_register[`GIE_BIT];

  // ****************************************************************
  // Instruction cycle enable
  // ****************************************************************
  assign cyc_en = (div_cnt == (TCY[7:0] - 8'h01));

  always @(posedge clk_i) begin
    if (int_rst || cyc_en) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Decode of the pending instruction
  // ****************************************************************
  wire [2:0] op = instr[`INSTR_OP_MSB:`INSTR_OP_LSB];
  wire sel_n = instr[`INSTR_N_BIT];
  wire [2:0] mode = instr[`INSTR_MODE_MSB:`INSTR_MODE_LSB];
  wire [5:0] k = instr[`INSTR_K_MSB:`INSTR_K_LSB];
  wire [15:0] k_ext = {{10{k[5]}}, k};
  wire [15:0] ptr = sel_n ? file_pointer_1 : file_pointer_0;
  wire exec = (state == S_PEND) && cyc_en;
  wire do_store = exec && (op == `OP_STORE);
  // Opcodes above the last defined one are refused at issue
  wire op_valid_in = (wb_dat_i[`INSTR_OP_MSB:`INSTR_OP_LSB] <= `OP_RETIRQ);

  reg [15:0] eff_addr;
  reg [15:0] ptr_after;

  // 16-bit adds drop the carry, so stepping wraps modulo 2^16
  always @* begin
    eff_addr = ptr;
    ptr_after = ptr;
    case (mode)
      `MODE_PREINC: begin
        eff_addr = ptr + 16'h0001;
        ptr_after = eff_addr;
      end
      `MODE_PREDEC: begin
        eff_addr = ptr - 16'h0001;
        ptr_after = eff_addr;
      end
      `MODE_POSTINC: begin
        ptr_after = ptr + 16'h0001;
      end
      `MODE_POSTDEC: begin
        ptr_after = ptr - 16'h0001;
      end
      `MODE_REL: begin
        eff_addr = ptr + k_ext;
      end
      default: begin
        eff_addr = ptr;
        ptr_after = ptr;
      end
    endcase
  end

  data_ram #(
    .AW(MEM_AW),
    .DW(8)
  ) u_ram (
    .clk_i(clk_i),
    .we_i(do_store),
    .waddr_i(eff_addr[MEM_AW-1:0]),
    .wdata_i(work),
    .raddr_i(mem_addr),
    .rdata_o(mem_rdata)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (bus_wr && wb_adr_i == `OFS_INSTR && wb_sel_i[0] && wb_sel_i[1]) begin
          next_state = S_PEND;
        end
      end
      S_PEND: begin
        if (cyc_en) begin
          if (op == `OP_RETIRQ) begin
            next_state = S_FLUSH;
          end else if (op == `OP_RESET) begin
            next_state = S_RST;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_FLUSH: begin
        if (cyc_en) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (int_rst) begin
      state <= S_IDLE;
    end else if (next_state == S_PEND && !op_valid_in) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      device_reset_o <= 1'b0;
    end else begin
      device_reset_o <= exec && (op == `OP_RESET);
    end
  end

  // ****************************************************************
  // Architectural registers
  // ****************************************************************
  wire wr_lo = bus_wr && wb_sel_i[0];
  wire wr_hi = bus_wr && wb_sel_i[1];

  always @(posedge clk_i) begin
    if (int_rst) begin
      instr <= 13'h0000;
    end else if (state == S_IDLE && wr_lo && wr_hi && wb_adr_i == `OFS_INSTR) begin
      instr <= wb_dat_i[12:0];
    end
  end

  always @(posedge clk_i) begin
    if (int_rst) begin
      work <= 8'h00;
    end else if (wr_lo && wb_adr_i == `OFS_WORK) begin
      work <= wb_dat_i[7:0];
    end
  end

  // Pointer writeback; no flag is touched by this path
  always @(posedge clk_i) begin
    if (int_rst) begin
      file_pointer_0 <= `RST_FP;
      file_pointer_1 <= `RST_FP;
    end else if (do_store) begin
      if (sel_n) begin
        file_pointer_1 <= ptr_after;
      end else begin
        file_pointer_0 <= ptr_after;
      end
    end else begin
      if (wb_adr_i == `OFS_FP0) begin
        if (wr_lo) file_pointer_0[7:0] <= wb_dat_i[7:0];
        if (wr_hi) file_pointer_0[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == `OFS_FP1) begin
        if (wr_lo) file_pointer_1[7:0] <= wb_dat_i[7:0];
        if (wr_hi) file_pointer_1[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always @(posedge clk_i) begin
    if (int_rst) begin
      option_reg <= `RST_OPTION;
    end else if (exec && op == `OP_OPTION) begin
      option_reg <= work;
    end else if (wr_lo && wb_adr_i == `OFS_OPTION) begin
      option_reg <= wb_dat_i[7:0];
    end
  end

  // Status flags belong to software here; of the instructions of this block
  // only the software reset writes them, and it clears them
  always @(posedge clk_i) begin
    if (int_rst) begin
      status_flags <= 3'h0;
    end else if (wr_lo && wb_adr_i == `OFS_FLAGS) begin
      status_flags <= wb_dat_i[2:0];
    end
  end

  // Survives the software reset; a pin reset or a software write sets the flag again.
  // The hardware clear wins over a software write in the same cycle.
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      power_control_register <= `RST_PWRCTL;
    end else if (state == S_RST) begin
      power_control_register[`RIFLAG_BIT] <= 1'b0;
    end else if (wr_lo && wb_adr_i == `OFS_PWRCTL) begin
      power_control_register <= wb_dat_i[7:0];
    end
  end

  // Hardware set of the enable wins over a software write
  always @(posedge clk_i) begin
    if (int_rst) begin
      irq_control_register <= 8'h00;
    end else begin
      if (wr_lo && wb_adr_i == `OFS_IRQCTL) begin
        irq_control_register <= wb_dat_i[7:0];
      end
      if (exec && op == `OP_RETIRQ) begin
        irq_control_register[`GIE_BIT] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Program counter and stack
  // ****************************************************************
  always @(posedge clk_i) begin
    if (int_rst) begin
      pc <= {PC_W{1'b0}};
    end else if (exec) begin
      if (op == `OP_RETIRQ) begin
        pc <= stack_top_entry;
      end else begin
        pc <= pc + {{(PC_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk_i) begin
    if (int_rst) begin
      stack_top_entry <= {PC_W{1'b0}};
      stack_ptr <= 4'h0;
    end else begin
      if (wb_adr_i == `OFS_STKTOP) begin
        if (wr_lo) stack_top_entry[7:0] <= wb_dat_i[7:0];
        if (wr_hi) stack_top_entry[PC_W-1:8] <= wb_dat_i[PC_W-1:8];
      end
      if (exec && op == `OP_RETIRQ) begin
        stack_ptr <= stack_ptr - 4'h1;
      end else if (wr_lo && wb_adr_i == `OFS_STKPTR) begin
        stack_ptr <= wb_dat_i[3:0];
      end
    end
  end

  always @(posedge clk_i) begin
    if (int_rst) begin
      mem_addr <= {MEM_AW{1'b0}};
    end else if (wr_lo && wb_adr_i == `OFS_MEMADDR) begin
      mem_addr <= wb_dat_i[MEM_AW-1:0];
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `OFS_INSTR: rd_mux = {19'h0, instr};
      `OFS_WORK: rd_mux = {24'h000000, work};
      `OFS_FP0: rd_mux = {16'h0000, file_pointer_0};
      `OFS_FP1: rd_mux = {16'h0000, file_pointer_1};
      `OFS_OPTION: rd_mux = {24'h000000, option_reg};
      `OFS_PWRCTL: rd_mux = {24'h000000, power_control_register};
      `OFS_IRQCTL: rd_mux = {24'h000000, irq_control_register};
      `OFS_PC: rd_mux = {{(32-PC_W){1'b0}}, pc};
      `OFS_STKTOP: rd_mux = {{(32-PC_W){1'b0}}, stack_top_entry};
      `OFS_STKPTR: rd_mux = {28'h0000000, stack_ptr};
      `OFS_MEMADDR: rd_mux = {{(32-MEM_AW){1'b0}}, mem_addr};
      `OFS_MEMDATA: rd_mux = {24'h000000, mem_rdata};
      `OFS_STATUS: rd_mux = {30'h0, state == S_FLUSH, state != S_IDLE};
      `OFS_FLAGS: rd_mux = {29'h0, status_flags};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Ack is registered so every access answers one edge after the request
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_mux : 32'h00000000;
    end
  end
endmodule // indirect_ops

// [indirect_ops_regs.vh]
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef INDIRECT_OPS_REGS_VH
`define INDIRECT_OPS_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_INSTR 8'h00
`define OFS_WORK 8'h04
`define OFS_FP0 8'h08
`define OFS_FP1 8'h0C
`define OFS_OPTION 8'h10
`define OFS_PWRCTL 8'h14
`define OFS_IRQCTL 8'h18
`define OFS_PC 8'h1C
`define OFS_STKTOP 8'h20
`define OFS_STKPTR 8'h24
`define OFS_MEMADDR 8'h28
`define OFS_MEMDATA 8'h2C
`define OFS_STATUS 8'h30
`define OFS_FLAGS 8'h34

// ****************************************************************
// Instruction word fields
// ****************************************************************
`define INSTR_OP_LSB 0
`define INSTR_OP_MSB 2
`define INSTR_N_BIT 3
`define INSTR_MODE_LSB 4
`define INSTR_MODE_MSB 6
`define INSTR_K_LSB 7
`define INSTR_K_MSB 12

`define OP_NOP 3'h0
`define OP_STORE 3'h1
`define OP_OPTION 3'h2
`define OP_RESET 3'h3
`define OP_RETIRQ 3'h4

`define MODE_PREINC 3'h0
`define MODE_PREDEC 3'h1
`define MODE_POSTINC 3'h2
`define MODE_POSTDEC 3'h3
`define MODE_REL 3'h4

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define RIFLAG_BIT 0
`define GIE_BIT 7
`define STATUS_BUSY_BIT 0
`define STATUS_FLUSH_BIT 1
`define RST_OPTION 8'hFF
`define RST_PWRCTL 8'h01
`define RST_FP 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 100
`define TCY_NS 400
`define TCY_CLKS (`TCY_NS / `CLK_PERIOD_NS)

`endif

// [data_ram.v]
// Purpose: Data memory written by the indirect store, read over the bus
// Assumes: One write port and one read port on the same clock
// Notes: Read data come out of a register, one cycle after the address
module data_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // data_ram

// [indirect_ops_properties.sv]
// Purpose: Port-level properties of indirect_ops
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the design from the testbench top file
module indirect_ops_chk #(
  parameter TCY = 4
) (
  input wire clk_i,
  input wire nrst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire device_reset_o,
  input wire [7:0] option_o,
  input wire global_irq_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cycles since the last bus answer; an instruction only lands a few cycles after one
  logic [7:0] idle;
  always @(posedge clk_i) begin
    if (!nrst_i || wb_ack_o) idle <= 8'h00;
    else if (idle != 8'hFF) idle <= idle + 8'h01;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_source_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  pin_reset_a: assert property (disable iff (1'b0) !nrst_i |=>
    (!wb_ack_o && !device_reset_o && option_o == 8'hFF && !global_irq_enable_o))
    else $error("outputs not cleared by reset");
  rst_pulse_a: assert property (device_reset_o |=> !device_reset_o) else $error("reset pulse too long");
  rst_clear_a: assert property (device_reset_o |=> ##[0:1]
    (option_o == 8'hFF && !global_irq_enable_o)) else $error("software reset left state");
  option_cause_a: assert property ($changed(option_o) |-> wb_ack_o || idle <= 3 * TCY)
    else $error("option changed without a request");
  irq_cause_a: assert property ($changed(global_irq_enable_o) |-> wb_ack_o || idle <= 3 * TCY)
    else $error("irq enable changed without a request");
  cover property (device_reset_o);
  cover property ($rose(global_irq_enable_o));
  cover property ($changed(option_o));
endmodule // indirect_ops_chk

// [indirect_ops_tb_top.sv]
// Purpose: Self-checking bench for indirect_ops
// Assumes: Instruction cycle shortened to 2 clocks
// Notes: Store cases in a table, special cases after it
module indirect_ops_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic n;
    logic [2:0] md;
    logic [5:0] k;
    logic [15:0] fp;
    logic [15:0] fpx;
    logic [7:0] ea;
  } row_t;
  logic clk_i, nrst_i, cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel, bsel;
  logic [31:0] dat, rd, pc0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, device_reset_o, global_irq_enable;
  wire [7:0] option_o;
  int n_fail, num_checks, cyc_cnt, n_rst;
  row_t rows [6] = '{
    '{1'b0, 3'h0, 6'h00, 16'h0010, 16'h0011, 8'h11},
    '{1'b1, 3'h1, 6'h00, 16'h0000, 16'hFFFF, 8'hFF},
    '{1'b0, 3'h2, 6'h00, 16'hFFFF, 16'h0000, 8'hFF},
    '{1'b1, 3'h3, 6'h00, 16'h0020, 16'h001F, 8'h20},
    '{1'b0, 3'h4, 6'h20, 16'h0040, 16'h0040, 8'h20},
    '{1'b1, 3'h4, 6'h1F, 16'h0100, 16'h0100, 8'h1F}};
  indirect_ops #(.TCY(2)) u_indirect_ops (
    .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .device_reset_o(device_reset_o), .option_o(option_o), .global_irq_enable_o(global_irq_enable));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= bsel;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic exec(input logic [31:0] ins);
    bus(1'b1, 8'h00, ins);
    repeat (20) begin
      bus(1'b0, 8'h30, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    chk({31'h0, rd[0]}, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (device_reset_o === 1'b1) n_rst++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    row_t r;
    {nrst_i, cyc, stb, we, adr, sel, dat} = '0;
    bsel = 4'h3;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    bus(1'b0, 8'h10, 32'h0); chk(rd, 32'hFF);
    bus(1'b0, 8'h14, 32'h0); chk(rd, 32'h1);
    bus(1'b0, 8'h08, 32'h0); chk(rd, 32'h0);
    bus(1'b1, 8'h34, 32'h5);
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, 8'h04, 32'hA0 + i);
      bus(1'b1, r.n ? 8'h0C : 8'h08, {16'h0, r.fp});
      exec({19'h0, r.k, r.md, r.n, 3'h1});
      bus(1'b0, r.n ? 8'h0C : 8'h08, 32'h0); chk(rd, {16'h0, r.fpx});
      bus(1'b1, 8'h28, {24'h0, r.ea});
      bus(1'b0, 8'h2C, 32'h0); chk(rd, 32'hA0 + i);
    end
    bus(1'b0, 8'h34, 32'h0); chk(rd, 32'h5);
    bus(1'b1, 8'h3C, 32'h77);
    bus(1'b0, 8'h3C, 32'h0); chk(rd, 32'h0);
    bus(1'b1, 8'h04, 32'h4F);
    exec(32'h2); chk({24'h0, option_o}, 32'h4F);
    // An issue with only the low lane enabled must be refused
    bus(1'b1, 8'h04, 32'h3C);
    bsel = 4'h1;
    bus(1'b1, 8'h00, 32'h2);
    bsel = 4'h3;
    bus(1'b0, 8'h30, 32'h0); chk(rd, 32'h0);
    chk({24'h0, option_o}, 32'h4F);
    bus(1'b0, 8'h1C, 32'h0);
    pc0 = rd;
    exec(32'h7);
    bus(1'b0, 8'h1C, 32'h0); chk(rd, pc0);
    exec(32'h0);
    bus(1'b0, 8'h1C, 32'h0); chk(rd, (pc0 + 32'h1) & 32'h7FFF);
    bus(1'b0, 8'h10, 32'h0); chk(rd, 32'h4F);
    bus(1'b1, 8'h20, 32'h1234);
    bus(1'b1, 8'h24, 32'h3);
    exec(32'h4);
    bus(1'b0, 8'h1C, 32'h0); chk(rd, 32'h1234);
    bus(1'b0, 8'h24, 32'h0); chk(rd, 32'h2);
    bus(1'b0, 8'h18, 32'h0); chk(rd, 32'h80);
    chk({31'h0, global_irq_enable}, 32'h1);
    bus(1'b0, 8'h34, 32'h0); chk(rd, 32'h5);
    // Second return: the flush cycle is still running at the first poll
    bus(1'b1, 8'h00, 32'h4);
    bus(1'b0, 8'h30, 32'h0); chk(rd, 32'h3);
    bus(1'b0, 8'h30, 32'h0); chk(rd, 32'h0);
    exec(32'h3);
    chk(n_rst, 32'h1);
    bus(1'b0, 8'h14, 32'h0); chk(rd, 32'h0);
    bus(1'b0, 8'h10, 32'h0); chk(rd, 32'hFF);
    chk({31'h0, global_irq_enable}, 32'h0);
    // Pin reset in mid-run sets the reset-cause flag again
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    bus(1'b0, 8'h14, 32'h0); chk(rd, 32'h1);
    bus(1'b0, 8'h08, 32'h0); chk(rd, 32'h0);
    report_and_stop();
  end
endmodule // indirect_ops_tb_top

bind indirect_ops indirect_ops_chk #(.TCY(TCY)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .device_reset_o(device_reset_o), .option_o(option_o),
  .global_irq_enable_o(global_irq_enable_o));
